// ---- trbs_pkg.sv ----
// Package for the table read and bit skip execution block.
// Assumes an 8-bit core with a 12-bit program counter and 15-bit program words.
package trbs_pkg;

	localparam int PC_W        = 12;
	localparam int ROM_W       = 15;
	localparam int DATA_W      = 8;
	localparam int MADDR_W     = 8;
	localparam int PAGE_W      = PC_W - DATA_W;
	localparam int HI_W        = ROM_W - DATA_W;

	// APB register offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_PTR_LOW  = 8'h04;
	localparam logic [7:0] REG_PTR_HIGH = 8'h08;
	localparam logic [7:0] REG_LATCH    = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;

	// Field positions
	localparam int CTRL_HIGH_EN_BIT = 0;

	// Reset values
	localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
	localparam logic [31:0]       APB_ZERO  = 32'h0000_0000;

	// Skip timing in instruction cycles
	localparam int SKIP_TAKEN_CYCLES = 2;
	localparam int SKIP_NONE_CYCLES  = 1;

	typedef enum logic [1:0] {
		TRBS_OP_NONE   = 2'b00,
		TRBS_OP_SKIPZ  = 2'b01,
		TRBS_OP_TABC   = 2'b10,
		TRBS_OP_TABL   = 2'b11
	} trbs_op_t;

	typedef enum logic [1:0] {
		TRBS_ST_IDLE  = 2'b00,
		TRBS_ST_DUMMY = 2'b01,
		TRBS_ST_FETCH = 2'b10
	} trbs_state_t;

	// Instruction issued by the core
	typedef struct packed {
		trbs_op_t           op;
		logic [MADDR_W-1:0] maddr;
		logic [2:0]         bit_sel;
	} trbs_instr_t;

	// Data memory write port
	typedef struct packed {
		logic               we;
		logic [MADDR_W-1:0] addr;
		logic [DATA_W-1:0]  data;
	} trbs_mem_wr_t;

endpackage : trbs_pkg

// ---- trbs_exec.sv ----
// Execution of skip_if_bit_zero and table_read_word in the core datapath.
// Assumes one instruction per core_clk, data memory byte given in the issue cycle,
// program memory answering in the same cycle as its address, APB master for pointers.
// Behaviour
// - Bit zero: discard next instruction, dummy cycle, 2 cycles; else 1 cycle.
// - High pointer enabled: TABC program address from low and high table pointers; TABL always uses the page.
// - Current-page form addresses by low pointer within the executing page.
// - Table read: low byte to data memory operand, high byte to latch.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module trbs_exec
	import trbs_pkg::*;
(
	input  wire logic                          core_clk,    // Core clock
	input  wire logic                          reset,       // Sync reset, high
	input  wire trbs_pkg::trbs_instr_t         instr,       // Issued instruction
	input  wire logic                          instr_valid, // Instruction issued
	input  wire logic [trbs_pkg::DATA_W-1:0]   mem_rdata,   // Operand byte
	input  wire logic [trbs_pkg::PC_W-1:0]     pc,          // Executing PC
	input  wire logic [trbs_pkg::ROM_W-1:0]    rom_rdata,   // Program word
	input  wire logic [5:0]                    flags_in,    // Status flags now
	output logic [trbs_pkg::PC_W-1:0]          rom_addr,    // Program address
	output logic                               rom_re,      // Program read
	output trbs_pkg::trbs_mem_wr_t             mem_wr,      // Data memory write
	output logic                               squash,      // Next instr discarded
	output logic                               busy,        // Core stall
	output logic [5:0]                         flags_out,   // Status flags after
	input  wire logic                          psel,        // APB select
	input  wire logic                          penable,     // APB enable
	input  wire logic                          pwrite,      // APB write
	input  wire logic [7:0]                    paddr,       // APB address
	input  wire logic [31:0]                   pwdata,      // APB write data
	output logic [31:0]                        prdata,      // APB read data
	output logic                               pready,      // APB ready
	output logic                               pslverr      // APB error
);
	import trbs_pkg::*;

	trbs_state_t          state_r, state_nxt;
	logic [DATA_W-1:0]    ptr_low_r, ptr_high_r, latch_r;
	logic                 high_en_r;
	logic [MADDR_W-1:0]   dest_r;
	logic                 pending_r;
	logic [31:0]          prdata_nxt;

	wire issue      = instr_valid && state_r == TRBS_ST_IDLE;
	wire bit_zero   = ~mem_rdata[instr.bit_sel];
	wire do_skip    = issue && instr.op == TRBS_OP_SKIPZ && bit_zero;
	wire do_tabc    = issue && instr.op == TRBS_OP_TABC;
	wire do_tabl    = issue && instr.op == TRBS_OP_TABL;
	wire do_table   = do_tabc || do_tabl;
	wire [PC_W-1:0] full_addr = {ptr_high_r[PAGE_W-1:0], ptr_low_r};
	wire [PC_W-1:0] page_addr = {pc[PC_W-1:DATA_W], ptr_low_r};
	wire [PC_W-1:0] addr_nxt  = high_en_r ? full_addr : page_addr;
	wire            fetch_done = state_r == TRBS_ST_FETCH;

	wire apb_acc = psel && penable;
	wire apb_wr  = apb_acc && pwrite;
	wire addr_ok = paddr == REG_CTRL || paddr == REG_PTR_LOW || paddr == REG_PTR_HIGH
		|| paddr == REG_LATCH || paddr == REG_STATUS;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TRBS_ST_IDLE: begin
				if (do_skip)
					state_nxt = TRBS_ST_DUMMY;
				else if (do_table)
					state_nxt = TRBS_ST_FETCH;
			end
			TRBS_ST_DUMMY: state_nxt = TRBS_ST_IDLE;
			TRBS_ST_FETCH: state_nxt = TRBS_ST_IDLE;
			default:       state_nxt = TRBS_ST_IDLE;
		endcase
	end

	always_comb begin
		prdata_nxt = APB_ZERO;
		case (paddr)
			REG_CTRL:     prdata_nxt = {31'h0000_0000, high_en_r};
			REG_PTR_LOW:  prdata_nxt = {24'h00_0000, ptr_low_r};
			REG_PTR_HIGH: prdata_nxt = {24'h00_0000, ptr_high_r};
			REG_LATCH:    prdata_nxt = {24'h00_0000, latch_r};
			REG_STATUS:   prdata_nxt = {30'h0000_0000, state_r};
			default:      prdata_nxt = APB_ZERO;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			state_r <= TRBS_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rom_addr <= '0;
			rom_re   <= 1'b0;
			dest_r   <= RST_BYTE;
		end else begin
			rom_re <= do_table;
			if (do_tabc)
				rom_addr <= addr_nxt;
			else if (do_tabl)
				rom_addr <= page_addr;
			if (do_table)
				dest_r <= instr.maddr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_wr  <= '0;
			latch_r <= RST_BYTE;
		end else begin
			mem_wr.we <= fetch_done;
			if (fetch_done) begin
				mem_wr.addr <= dest_r;
				mem_wr.data <= rom_rdata[DATA_W-1:0];
				latch_r     <= {1'b0, rom_rdata[ROM_W-1:DATA_W]};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			squash    <= 1'b0;
			busy      <= 1'b0;
			flags_out <= 6'h00;
		end else begin
			squash    <= do_skip;
			busy      <= do_table || state_nxt != TRBS_ST_IDLE;
			flags_out <= flags_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr_low_r  <= RST_BYTE;
			ptr_high_r <= RST_BYTE;
			high_en_r  <= 1'b0;
			prdata     <= APB_ZERO;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= prdata_nxt;
			if (apb_wr && pready) begin
				if (paddr == REG_CTRL)
					high_en_r <= pwdata[CTRL_HIGH_EN_BIT];
				if (paddr == REG_PTR_LOW)
					ptr_low_r <= pwdata[DATA_W-1:0];
				if (paddr == REG_PTR_HIGH)
					ptr_high_r <= pwdata[DATA_W-1:0];
			end
		end
	end

	// High in the cycle in which the program word arrives
	logic pend_tab_r;
	always_ff @(posedge core_clk) begin
		if (reset)
			pend_tab_r <= 1'b0;
		else
			pend_tab_r <= do_table;
	end

	// Skip timing and discard of the following instruction
	AST_SKIP_SQUASH: assert property (@(posedge core_clk) disable iff (reset)
		do_skip |=> squash && state_r == TRBS_ST_DUMMY ##1 state_r == TRBS_ST_IDLE)
		else $error("skip did not take two cycles");
	AST_NO_SKIP: assert property (@(posedge core_clk) disable iff (reset)
		issue && instr.op == TRBS_OP_SKIPZ && !bit_zero |=> !squash && state_r == TRBS_ST_IDLE)
		else $error("skip taken on set bit");
	AST_SKIP_BUSY: assert property (@(posedge core_clk) disable iff (reset)
		do_skip |=> busy ##1 !busy)
		else $error("skip stall wrong");
	AST_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (reset)
		issue && instr.op == TRBS_OP_SKIPZ && !bit_zero |=> !busy)
		else $error("untaken skip stalled");
	AST_DISCARD: assert property (@(posedge core_clk) disable iff (reset)
		state_r == TRBS_ST_DUMMY |=> !rom_re && !squash && !busy)
		else $error("discarded instruction acted");
	AST_NONE_QUIET: assert property (@(posedge core_clk) disable iff (reset)
		issue && instr.op == TRBS_OP_NONE |=> !squash && !rom_re && !busy)
		else $error("empty issue acted");
	// Table read addressing
	AST_ADDR_HIGH: assert property (@(posedge core_clk) disable iff (reset)
		do_tabc && high_en_r |=> rom_addr == $past(full_addr) && rom_re)
		else $error("high pointer not used");
	AST_ADDR_PAGE: assert property (@(posedge core_clk) disable iff (reset)
		do_tabl |=> rom_addr[DATA_W-1:0] == $past(ptr_low_r)
			&& rom_addr[PC_W-1:DATA_W] == $past(pc[PC_W-1:DATA_W]))
		else $error("page address wrong");
	AST_ADDR_CUR: assert property (@(posedge core_clk) disable iff (reset)
		do_tabc && !high_en_r |=> rom_addr[DATA_W-1:0] == $past(ptr_low_r)
			&& rom_addr[PC_W-1:DATA_W] == $past(pc[PC_W-1:DATA_W]))
		else $error("current page address wrong");
	// Table read results
	AST_TAB_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		do_table |=> ##1 mem_wr.we && mem_wr.addr == $past(instr.maddr, 2))
		else $error("table write missing");
	AST_TAB_DATA: assert property (@(posedge core_clk) disable iff (reset)
		pend_tab_r |=> mem_wr.data == $past(rom_rdata[DATA_W-1:0]))
		else $error("table low byte wrong");
	AST_LATCH: assert property (@(posedge core_clk) disable iff (reset)
		pend_tab_r |=> latch_r[HI_W-1:0] == $past(rom_rdata[ROM_W-1:DATA_W]))
		else $error("latch not loaded");
	AST_LATCH_TOP: assert property (@(posedge core_clk) disable iff (reset)
		pend_tab_r |=> !latch_r[DATA_W-1])
		else $error("latch top bit set");
	AST_FETCH_ONCE: assert property (@(posedge core_clk) disable iff (reset)
		rom_re |=> !rom_re)
		else $error("program read longer than one cycle");
	AST_WRITE_ONCE: assert property (@(posedge core_clk) disable iff (reset)
		mem_wr.we |=> !mem_wr.we)
		else $error("data write longer than one cycle");
	AST_FLAGS: assert property (@(posedge core_clk) disable iff (reset)
		(do_skip || do_table) |=> flags_out == $past(flags_in))
		else $error("flags changed");
	AST_BUSY: assert property (@(posedge core_clk) disable iff (reset)
		do_table |=> busy ##1 !busy)
		else $error("table read stall wrong");

endmodule : trbs_exec
`default_nettype wire

// ---- test_table_read_and_bit_skip_exec.sv ----
// Testbench for the table read and bit skip execution block.
// Assumes trbs_pkg and trbs_exec are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_table_read_and_bit_skip_exec;
	import trbs_pkg::*;
	logic core_clk = 0, reset = 1, instr_valid = 0, psel = 0, penable = 0, pwrite = 0;
	trbs_instr_t instr = '0;
	logic [7:0] mem_rdata = '0, paddr = '0;
	logic [11:0] pc = 12'hA37;
	logic [14:0] rom_rdata = 15'h6BC5;
	logic [5:0] flags_in = 6'h2A;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [11:0] rom_addr;
	trbs_mem_wr_t mem_wr;
	logic rom_re, squash, busy, pready, pslverr, err;
	logic [5:0] flags_out;
	int miscompares = 0, checked = 0;
	trbs_exec i_dut (.core_clk(core_clk), .reset(reset), .instr(instr),
		.instr_valid(instr_valid), .mem_rdata(mem_rdata), .pc(pc), .rom_rdata(rom_rdata),
		.flags_in(flags_in), .rom_addr(rom_addr), .rom_re(rom_re), .mem_wr(mem_wr),
		.squash(squash), .busy(busy), .flags_out(flags_out), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	always #5 core_clk = ~core_clk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic exe(input trbs_op_t op, input logic [2:0] b, input logic [7:0] d);
		@(posedge core_clk);
		instr       <= '{op, 8'h44, b};
		mem_rdata   <= d;
		instr_valid <= 1'b1;
		flags_in    <= flags_in + 6'h07;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
	endtask : exe
	task automatic tab(input trbs_op_t op, input logic [11:0] a);
		exe(op, 3'd0, 8'h00);
		`CHK("rom_re", 1'b1, rom_re)
		`CHK("rom_addr", a, rom_addr)
		`CHK("tab_busy", 1'b1, busy)
		@(posedge core_clk);
		#1;
		`CHK("mem_wr", {1'b1, 8'h44, 8'hC5}, mem_wr)
		`CHK("tab_done", 1'b0, busy)
		`CHK("flags", flags_in, flags_out)
	endtask : tab
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 0;
		@(posedge core_clk);
		#1;
		`CHK("busy", 1'b0, busy)
		apb(1, REG_PTR_LOW, 32'h5A);
		apb(1, REG_PTR_HIGH, 32'h3);
		apb(0, REG_PTR_LOW, 0);
		`CHK("ptr_low", 32'h5A, rd)
		`CHK("mapped", 1'b0, err)
		apb(0, 8'h20, 0);
		`CHK("unmapped", 1'b1, err)
		for (int b = 0; b < 8; b++) begin
			exe(TRBS_OP_SKIPZ, b[2:0], 8'h01 << b);
			`CHK("no_skip", 1'b0, squash)
			`CHK("no_skip_busy", 1'b0, busy)
			exe(TRBS_OP_SKIPZ, b[2:0], ~(8'h01 << b));
			`CHK("skip", 1'b1, squash)
			`CHK("skip_busy", 1'b1, busy)
			`CHK("flags", flags_in, flags_out)
		end
		exe(TRBS_OP_NONE, 3'd0, 8'h00);
		`CHK("none_squash", 1'b0, squash)
		`CHK("none_read", 1'b0, rom_re)
		tab(TRBS_OP_TABL, 12'hA5A);
		tab(TRBS_OP_TABC, 12'hA5A);
		apb(1, REG_CTRL, 32'h1);
		flags_in <= 6'h15;
		tab(TRBS_OP_TABC, 12'h35A);
		apb(0, REG_LATCH, 0);
		`CHK("latch", 32'h6B, rd)
		pc <= 12'h5F0;
		tab(TRBS_OP_TABL, 12'h55A);
		tab(TRBS_OP_TABC, 12'h35A);
		apb(1, REG_CTRL, 32'h0);
		tab(TRBS_OP_TABC, 12'h55A);
		finish_test();
	end
endmodule : test_table_read_and_bit_skip_exec
`default_nettype wire
